// [src/aacc_defines.svh]
// Constants of the auto-answer call controller: clock, timing, register map, fields.
`ifndef AACC_DEFINES_SVH
`define AACC_DEFINES_SVH

`define AACC_CLK_HZ 100000000
`define AACC_CYC_PER_MS (`AACC_CLK_HZ / 1000)

// Sequence times in milliseconds.
`define AACC_BILL_MS 2000
`define AACC_NOCAR_MS 10000
`define AACC_HOLD_MS 100
`define AACC_CDON_MS 10
`define AACC_CTS_MS 200

// The same times in clock cycles.
`define AACC_BILL_CYC (`AACC_BILL_MS * `AACC_CYC_PER_MS)
`define AACC_NOCAR_CYC (`AACC_NOCAR_MS * `AACC_CYC_PER_MS)
`define AACC_HOLD_CYC (`AACC_HOLD_MS * `AACC_CYC_PER_MS)
`define AACC_CDON_CYC (`AACC_CDON_MS * `AACC_CYC_PER_MS)
`define AACC_CTS_CYC (`AACC_CTS_MS * `AACC_CYC_PER_MS)

// Register byte offsets.
`define AACC_OFS_CTRL 8'h00
`define AACC_OFS_STATUS 8'h04
`define AACC_OFS_BILL 8'h08
`define AACC_OFS_NOCAR 8'h0c
`define AACC_OFS_HOLD 8'h10
`define AACC_OFS_CDON 8'h14
`define AACC_OFS_CTS 8'h18

// Control register fields and reset value.
`define AACC_CTRL_AUTO 0
`define AACC_CTRL_ORIG 1
`define AACC_CTRL_LOOP 2
`define AACC_CTRL_HDX 3
`define AACC_CTRL_W 4
`define AACC_CTRL_RST 4'h0

`endif

// [src/aacc_pkg.sv]
// Types shared by the auto-answer call controller modules.
package aacc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RING,
		ST_BILL,
		ST_ANS_TONE,
		ST_VOICE,
		ST_ORG_WAIT,
		ST_ORG_CTS,
		ST_DATA
	} aacc_state_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic done;
	} aacc_tmr_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic hit;
	} aacc_dly_t;

	typedef struct packed {
		logic [31:0] bill;
		logic [31:0] nocar;
		logic [31:0] hold;
		logic [31:0] cdon;
		logic [31:0] cts;
	} aacc_times_t;

	// Line-side controls toward the analog front end.
	typedef struct packed {
		logic off_hook;
		logic line_to_modem;
		logic answer_tone;
		logic tx_enable;
		logic tx_line_data;
	} aacc_line_t;

	// Terminal-side circuits, all active low except the data.
	typedef struct packed {
		logic rx_serial_out;
		logic clear_to_send_n;
		logic data_set_ready_n;
		logic delayed_carrier_found_n;
		logic ring_indicator_n;
	} aacc_dte_t;

	typedef struct packed {
		aacc_state_t st;
		logic orig;
		logic [3:0] ctrl;
		aacc_times_t times;
		logic carrier_off;
		logic connect_led;
		aacc_line_t line;
		aacc_dte_t dte;
		logic ack;
		logic [31:0] rdata;
	} aacc_main_t;

endpackage

// [src/aacc_timer.sv]
// Loadable down-counter giving a one-cycle pulse when it runs out.
`timescale 1ns/1ps
module aacc_timer (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic load, // reload the count, retriggers the timer
	input wire logic [31:0] load_val, // terminal count in cycles
	output logic done // one-cycle pulse on expiry
);

	aacc_pkg::aacc_tmr_t s_reg;
	aacc_pkg::aacc_tmr_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (load) begin
			s_next.cnt = load_val;
		end else if (s_reg.cnt != 32'h0) begin
			s_next.cnt = s_reg.cnt - 32'h1;
			s_next.done = (s_reg.cnt == 32'h1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done = s_reg.done;

endmodule

// [src/aacc_ondelay.sv]
// On-delay filter: output rises after the input has stood high for the target count.
`timescale 1ns/1ps
module aacc_ondelay (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic level_in, // raw level, active high
	input wire logic [31:0] target, // on-delay in cycles
	output logic level_out // delayed level, drops at once
);

	aacc_pkg::aacc_dly_t s_reg;
	aacc_pkg::aacc_dly_t s_next;

	always_comb begin
		s_next = s_reg;
		if (!level_in) begin
			s_next.cnt = 32'h0;
			s_next.hit = 1'b0;
		end else begin
			if (s_reg.cnt < target) begin
				s_next.cnt = s_reg.cnt + 32'h1;
			end
			s_next.hit = (s_next.cnt >= target);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level_out = s_reg.hit;

endmodule

// [src/aacc_ctrl.sv]
// Auto-answer call controller for a low-speed FSK modem, with a Wishbone register port.
//
// Behaviour
// - Loopback returns data, request, and remodulates line.
// - Squelch transmitter two seconds for billing.
// - No carrier in ten seconds: drop line.
// - Expired 0.1 second hold timer disconnects line.
// - After ringing ends: data-set-ready and off-hook.
// - After billing delay send answer mark tone.
// - Originator hearing answer tone enters data mode.
// - Originator carrier detect only after on-delay.
// - Then unsquelch, send mark, start clear delay.
// - Answerer carrier detect after on-delay.
// - Answerer asserts clear-to-send after carrier detect.
// - Originator data state after clear delay expires.
// - Abort on no response or long carrier loss.
// - Connect indicator: call established and off-hook.
// - Latch dc loop and the carrier-off condition.
// - Manual call: voice until answer, then data.
// - Half duplex: clear-to-send is delayed request.
// - Receive output held at mark without carrier.
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "aacc_defines.svh"
module aacc_ctrl #(
	parameter logic [31:0] BILL_CYC = `AACC_BILL_CYC, // billing delay
	parameter logic [31:0] NOCAR_CYC = `AACC_NOCAR_CYC, // no-carrier timeout
	parameter logic [31:0] HOLD_CYC = `AACC_HOLD_CYC, // carrier-loss hold
	parameter logic [31:0] CDON_CYC = `AACC_CDON_CYC, // carrier-detect on-delay
	parameter logic [31:0] CTS_CYC = `AACC_CTS_CYC // clear-to-send delay
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic ring_detect, // ringing voltage present, active high
	input wire logic carrier_raw, // undelayed carrier detect, active high
	input wire logic rx_line_data, // demodulated receive data
	input wire logic tx_serial_in, // transmit data from terminal
	input wire logic send_request_n, // request to send, active low
	input wire logic terminal_ready_n, // data terminal ready, active low
	output aacc_pkg::aacc_line_t line_o, // controls toward the line front end
	output aacc_pkg::aacc_dte_t dte_o, // circuits toward the terminal
	output logic connect_led // call established indicator
);

	aacc_pkg::aacc_main_t s_reg;
	aacc_pkg::aacc_main_t s_next;
	logic seq_load;
	logic [31:0] seq_val;
	logic seq_done;
	logic hold_done;
	logic cd_ok;
	logic rts_ok;
	logic [31:0] ctrl_word;

	// Byte-lane merge of a write into an existing word.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return r;
	endfunction

	// States in which the dc loop is closed and the modem owns the line.
	function automatic logic in_call(input aacc_pkg::aacc_state_t st);
		return (st == aacc_pkg::ST_BILL) || (st == aacc_pkg::ST_ANS_TONE) ||
			(st == aacc_pkg::ST_ORG_WAIT) || (st == aacc_pkg::ST_ORG_CTS) ||
			(st == aacc_pkg::ST_DATA);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Timers.

	aacc_timer u_seq (
		.clk(clk),
		.rst_n(rst_n),
		.load(seq_load),
		.load_val(seq_val),
		.done(seq_done)
	);

	// retriggerable hold timer
	// Kept loaded while carrier is present, so it only runs out once the carrier has gone.
	aacc_timer u_hold (
		.clk(clk),
		.rst_n(rst_n),
		.load(!s_reg.carrier_off),
		.load_val(s_reg.times.hold),
		.done(hold_done)
	);

	aacc_ondelay u_cdon (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(carrier_raw),
		.target(s_reg.times.cdon),
		.level_out(cd_ok)
	);

	aacc_ondelay u_rts (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(!send_request_n),
		.target(s_reg.times.cts),
		.level_out(rts_ok)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		s_next = s_reg;
		seq_load = 1'b0;
		seq_val = s_reg.times.bill;

		// Register port: one wait cycle, ack for a single cycle, unmapped reads give zero.
		s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
		s_next.rdata = 32'h0;
		ctrl_word = wmerge({28'h0, s_reg.ctrl}, wb_dat_i, wb_sel_i);
		// Writes land at the edge at which the master samples ack high, so an abort cannot half-write.
		if (s_reg.ack && wb_cyc_i && wb_stb_i) begin
			if (wb_we_i) begin
				unique case (wb_adr_i)
					`AACC_OFS_CTRL: begin
						s_next.ctrl = ctrl_word[`AACC_CTRL_W-1:0];
					end
					`AACC_OFS_BILL: s_next.times.bill = wmerge(s_reg.times.bill, wb_dat_i, wb_sel_i);
					`AACC_OFS_NOCAR: s_next.times.nocar = wmerge(s_reg.times.nocar, wb_dat_i, wb_sel_i);
					`AACC_OFS_HOLD: s_next.times.hold = wmerge(s_reg.times.hold, wb_dat_i, wb_sel_i);
					`AACC_OFS_CDON: s_next.times.cdon = wmerge(s_reg.times.cdon, wb_dat_i, wb_sel_i);
					`AACC_OFS_CTS: s_next.times.cts = wmerge(s_reg.times.cts, wb_dat_i, wb_sel_i);
					default: begin
					end
				endcase
			end
		end
		if (s_next.ack) begin
			if (!wb_we_i) begin
				unique case (wb_adr_i)
					`AACC_OFS_CTRL: s_next.rdata = {28'h0, s_reg.ctrl};
					`AACC_OFS_STATUS: begin
						s_next.rdata = {22'h0, s_reg.connect_led, s_reg.line.off_hook,
							s_reg.carrier_off, rts_ok, cd_ok, carrier_raw, ring_detect,
							s_reg.st};
					end
					`AACC_OFS_BILL: s_next.rdata = s_reg.times.bill;
					`AACC_OFS_NOCAR: s_next.rdata = s_reg.times.nocar;
					`AACC_OFS_HOLD: s_next.rdata = s_reg.times.hold;
					`AACC_OFS_CDON: s_next.rdata = s_reg.times.cdon;
					`AACC_OFS_CTS: s_next.rdata = s_reg.times.cts;
					default: s_next.rdata = 32'h0;
				endcase
			end
		end

		// Call sequence.
		unique case (s_reg.st)
			aacc_pkg::ST_IDLE: begin
				s_next.orig = 1'b0;
				if (!terminal_ready_n) begin
					if (s_reg.ctrl[`AACC_CTRL_ORIG]) begin
						s_next.st = aacc_pkg::ST_VOICE;
					end else if (s_reg.ctrl[`AACC_CTRL_AUTO] && ring_detect) begin
						s_next.st = aacc_pkg::ST_RING;
					end
				end
			end
			aacc_pkg::ST_RING: begin
				if (!ring_detect) begin
					seq_load = 1'b1;
					seq_val = s_reg.times.bill;
					s_next.st = aacc_pkg::ST_BILL;
				end
			end
			aacc_pkg::ST_BILL: begin
				if (seq_done) begin
					seq_load = 1'b1;
					seq_val = s_reg.times.nocar;
					s_next.st = aacc_pkg::ST_ANS_TONE;
				end
			end
			aacc_pkg::ST_ANS_TONE: begin
				if (cd_ok) begin
					s_next.st = aacc_pkg::ST_DATA;
				end else if (seq_done) begin
					s_next.st = aacc_pkg::ST_IDLE;
				end
			end
			aacc_pkg::ST_VOICE: begin
				if (carrier_raw) begin
					s_next.orig = 1'b1;
					seq_load = 1'b1;
					seq_val = s_reg.times.nocar;
					s_next.st = aacc_pkg::ST_ORG_WAIT;
				end
			end
			aacc_pkg::ST_ORG_WAIT: begin
				if (cd_ok) begin
					seq_load = 1'b1;
					seq_val = s_reg.times.cts;
					s_next.st = aacc_pkg::ST_ORG_CTS;
				end else if (seq_done) begin
					s_next.st = aacc_pkg::ST_IDLE;
				end
			end
			aacc_pkg::ST_ORG_CTS: begin
				if (seq_done) begin
					s_next.st = aacc_pkg::ST_DATA;
				end
			end
			aacc_pkg::ST_DATA: begin
			end
		endcase

		if ((s_reg.st == aacc_pkg::ST_ORG_CTS || s_reg.st == aacc_pkg::ST_DATA) && hold_done) begin
			s_next.st = aacc_pkg::ST_IDLE;
		end
		// A terminal that is no longer ready hangs the call up at once.
		if (terminal_ready_n && s_reg.st != aacc_pkg::ST_IDLE) begin
			s_next.st = aacc_pkg::ST_IDLE;
		end

		if (cd_ok || !in_call(s_next.st)) begin
			s_next.carrier_off = 1'b0;
		end
		if (!cd_ok && (s_reg.st == aacc_pkg::ST_ORG_CTS || s_reg.st == aacc_pkg::ST_DATA)) begin
			s_next.carrier_off = 1'b1;
		end

		// Line-side outputs, from the next state so they change with it, except tx_line_data in loopback, which follows rx_line_data.
		// dc loop latch
		s_next.line.off_hook = in_call(s_next.st);
		s_next.line.line_to_modem = in_call(s_next.st);
		s_next.line.answer_tone = in_call(s_next.st) && !s_next.orig;
		s_next.line.tx_enable = (s_next.st == aacc_pkg::ST_ANS_TONE) ||
			(s_next.st == aacc_pkg::ST_ORG_CTS) || (s_next.st == aacc_pkg::ST_DATA);
		if (s_reg.ctrl[`AACC_CTRL_LOOP]) begin
			s_next.line.tx_line_data = rx_line_data;
		end else if (s_next.st == aacc_pkg::ST_DATA) begin
			s_next.line.tx_line_data = tx_serial_in;
		end else begin
			s_next.line.tx_line_data = 1'b1;
		end

		// Terminal-side outputs.
		// data-set-ready with off-hook
		s_next.dte.data_set_ready_n = !in_call(s_next.st);
		s_next.dte.ring_indicator_n = !ring_detect;
		s_next.dte.delayed_carrier_found_n = !cd_ok;
		if (s_reg.ctrl[`AACC_CTRL_LOOP]) begin
			s_next.dte.rx_serial_out = tx_serial_in;
		end else if (!cd_ok) begin
			s_next.dte.rx_serial_out = 1'b1;
		end else begin
			s_next.dte.rx_serial_out = rx_line_data;
		end
		if (s_reg.ctrl[`AACC_CTRL_LOOP]) begin
			s_next.dte.clear_to_send_n = send_request_n;
		end else if (s_reg.ctrl[`AACC_CTRL_HDX]) begin
			s_next.dte.clear_to_send_n = !(rts_ok && s_next.st == aacc_pkg::ST_DATA);
		end else begin
			s_next.dte.clear_to_send_n = (s_next.st != aacc_pkg::ST_DATA);
		end

		s_next.connect_led = (s_next.st == aacc_pkg::ST_DATA) && s_next.line.off_hook;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg.st <= aacc_pkg::ST_IDLE;
			s_reg.orig <= 1'b0;
			s_reg.ctrl <= `AACC_CTRL_RST;
			s_reg.times.bill <= BILL_CYC;
			s_reg.times.nocar <= NOCAR_CYC;
			s_reg.times.hold <= HOLD_CYC;
			s_reg.times.cdon <= CDON_CYC;
			s_reg.times.cts <= CTS_CYC;
			s_reg.carrier_off <= 1'b0;
			s_reg.connect_led <= 1'b0;
			s_reg.line <= '0;
			s_reg.line.tx_line_data <= 1'b1;
			s_reg.dte <= '1;
			s_reg.ack <= 1'b0;
			s_reg.rdata <= 32'h0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_dat_o = s_reg.rdata;
	assign wb_ack_o = s_reg.ack;
	assign line_o = s_reg.line;
	assign dte_o = s_reg.dte;
	assign connect_led = s_reg.connect_led;

endmodule

// [bench/aacc_ctrl_monitor.sv]
// Checker of call sequencing and bus handshake at the controller ports.
`timescale 1ns/1ps
module aacc_ctrl_monitor #(
	parameter logic [31:0] BILL_CYC = 32'h14, // billing delay
	parameter logic [31:0] NOCAR_CYC = 32'h3c, // no-carrier timeout
	parameter logic [31:0] HOLD_CYC = 32'ha, // carrier-loss hold
	parameter logic [31:0] CDON_CYC = 32'h4, // carrier on-delay
	parameter logic [31:0] CTS_CYC = 32'h8 // clear-to-send delay
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_ack_o, // bus acknowledge
	input wire logic carrier_raw, // raw carrier
	input wire aacc_pkg::aacc_line_t line_o, // line controls
	input wire aacc_pkg::aacc_dte_t dte_o, // terminal circuits
	input wire logic connect_led // call indicator
);
	localparam int BLO = BILL_CYC - 2;
	localparam int BHI = BILL_CYC + 6;
	localparam int HHI = HOLD_CYC + 4;
	localparam int NMAX = BILL_CYC + NOCAR_CYC + 8;
	logic [31:0] raw_cnt;
	logic [31:0] nocd_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Runs of raw carrier and of an off-hook line without carrier.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_cnt <= 32'h0;
			nocd_cnt <= 32'h0;
		end else begin
			raw_cnt <= carrier_raw ? raw_cnt + 32'h1 : 32'h0;
			nocd_cnt <= (line_o.off_hook && dte_o.delayed_carrier_found_n) ? nocd_cnt + 32'h1 : 32'h0;
		end
	end
	sequence s_answer;
		$rose(line_o.off_hook) && line_o.answer_tone;
	endsequence
	property p_led; connect_led |-> line_o.off_hook; endproperty
	a_led: assert property (p_led) else $error("indicator lit on hook");
	property p_answer; s_answer |-> !dte_o.data_set_ready_n && !line_o.tx_enable; endproperty
	a_answer: assert property (p_answer) else $error("answer without ready");
	property p_squelch; s_answer |-> ##1 (!line_o.tx_enable)[*8]; endproperty
	a_squelch: assert property (p_squelch) else $error("transmit not squelched");
	property p_tone; s_answer |-> ##[BLO:BHI] (line_o.tx_enable || !line_o.off_hook); endproperty
	a_tone: assert property (p_tone) else $error("answer tone late");
	property p_ondelay; $fell(dte_o.delayed_carrier_found_n) |-> raw_cnt >= CDON_CYC; endproperty
	a_ondelay: assert property (p_ondelay) else $error("carrier found early");
	property p_cts;
		$fell(dte_o.delayed_carrier_found_n) && line_o.answer_tone
			|-> ##[1:3] (!dte_o.clear_to_send_n && connect_led);
	endproperty
	a_cts: assert property (p_cts) else $error("answerer clear missing");
	property p_orig;
		$fell(dte_o.delayed_carrier_found_n) && !line_o.answer_tone && line_o.off_hook
			|-> ##[1:2] (line_o.tx_enable && dte_o.clear_to_send_n)[*6];
	endproperty
	a_orig: assert property (p_orig) else $error("originate clear too soon");
	property p_hold;
		$rose(dte_o.delayed_carrier_found_n) && connect_led
			|-> ##[1:HHI] (!line_o.off_hook || !dte_o.delayed_carrier_found_n);
	endproperty
	a_hold: assert property (p_hold) else $error("line held after loss");
	property p_nocar; nocd_cnt <= NMAX; endproperty
	a_nocar: assert property (p_nocar) else $error("line held without carrier");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus answer wrong");
	c_drop: cover property ($fell(connect_led));
	c_tone: cover property ($rose(line_o.tx_enable) && line_o.answer_tone);
	c_orig: cover property ($fell(dte_o.clear_to_send_n) && !line_o.answer_tone);
endmodule
bind aacc_ctrl aacc_ctrl_monitor #(.BILL_CYC(BILL_CYC), .NOCAR_CYC(NOCAR_CYC),
	.HOLD_CYC(HOLD_CYC), .CDON_CYC(CDON_CYC), .CTS_CYC(CTS_CYC)) i_aacc_ctrl_monitor (
	.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .carrier_raw(carrier_raw), .line_o(line_o), .dte_o(dte_o),
	.connect_led(connect_led));

// [bench/aacc_term_model.sv]
// Data terminal model driving the terminal-side circuits.
`timescale 1ns/1ps
module aacc_term_model (
	input wire logic clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic want_ready, // terminal powered and operating
	input wire logic want_send, // terminal has data to send
	input wire logic tx_bit, // next transmit bit
	output logic terminal_ready_n, // data terminal ready, active low
	output logic send_request_n, // request to send, active low
	output logic tx_serial_in // transmit data
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			terminal_ready_n <= 1'b1;
			send_request_n <= 1'b1;
			tx_serial_in <= 1'b1;
		end else begin
			terminal_ready_n <= !want_ready;
			send_request_n <= !want_send;
			tx_serial_in <= tx_bit;
		end
	end
endmodule

// [bench/aacc_ctrl_bench.sv]
// Self-checking bench of the call controller with a terminal model.
`timescale 1ns/1ps
module aacc_ctrl_bench;
	localparam int BILL = 20;
	localparam int NOCAR = 60;
	localparam int HOLD = 10;
	logic clk, rst_n, cyc, stb, we, ring, car, rxd, want_rdy, want_snd, txb, ack, led;
	logic dtr_n, rts_n, txd;
	logic [7:0] adr;
	logic [31:0] wdat, rdat;
	logic [63:0] nt;
	logic [63:0] exp_q[$];
	aacc_pkg::aacc_line_t line;
	aacc_pkg::aacc_dte_t dte;
	int miscompares, checked, ticks;
	aacc_ctrl #(.BILL_CYC(BILL), .NOCAR_CYC(NOCAR), .HOLD_CYC(HOLD), .CDON_CYC(4),
		.CTS_CYC(8)) i_aacc_ctrl (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ring_detect(ring), .carrier_raw(car), .rx_line_data(rxd),
		.tx_serial_in(txd), .send_request_n(rts_n), .terminal_ready_n(dtr_n),
		.line_o(line), .dte_o(dte), .connect_led(led));
	aacc_term_model i_aacc_term_model (.clk(clk), .rst_n(rst_n), .want_ready(want_rdy),
		.want_send(want_snd), .tx_bit(txb), .terminal_ready_n(dtr_n),
		.send_request_n(rts_n), .tx_serial_in(txd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cy(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		exp_q.push_back({m, e});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Read data is matched against the oldest pending note.
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			nt = exp_q.pop_front();
			chk("read data", nt[31:0], rdat & nt[63:32]);
		end
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 3000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		int unsigned r;
		{cyc, stb, we, ring, car, rxd, want_snd, txb, adr, wdat} = '0;
		rst_n = 1'b0;
		want_rdy = 1'b1;
		r = $urandom(32'hb4d900fa);
		cy(8);
		rst_n <= 1'b1;
		rd(8'h00, 32'h0, 32'hf);
		rd(8'h08, BILL, 32'hffffffff);
		rd(8'h0c, NOCAR, 32'hffffffff);
		rd(8'h10, HOLD, 32'hffffffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		bus(1'b1, 8'h00, 32'h1);
		rd(8'h00, 32'h1, 32'hf);
		////////////////////////////////////////////////////////////////////////
		ring <= 1'b1;
		cy(3);
		chk("ring ind", 0, dte.ring_indicator_n);
		ring <= 1'b0;
		cy(3);
		chk("off hook", 1, line.off_hook);
		chk("set ready", 0, dte.data_set_ready_n);
		chk("tx enable", 0, line.tx_enable);
		chk("answer tone", 1, line.answer_tone);
		cy(BILL - 6);
		chk("tx enable", 0, line.tx_enable);
		cy(8);
		chk("tx enable", 1, line.tx_enable);
		chk("tx mark", 1, line.tx_line_data);
		car <= 1'b1;
		cy(3);
		chk("carrier found", 1, dte.delayed_carrier_found_n);
		cy(7);
		chk("clear", 0, dte.clear_to_send_n);
		chk("led", 1, led);
		repeat (4) begin
			r = $urandom;
			rxd <= r[0];
			txb <= r[1];
			cy(3);
			chk("rx out", r[0], dte.rx_serial_out);
			chk("tx line", r[1], line.tx_line_data);
		end
		rxd <= 1'b0;
		car <= 1'b0;
		cy(3);
		chk("rx mark", 1, dte.rx_serial_out);
		rd(8'h04, 32'h80, 32'h80);
		cy(HOLD + 4);
		chk("off hook", 0, line.off_hook);
		chk("led", 0, led);
		rd(8'h04, 32'h0, 32'h7);
		////////////////////////////////////////////////////////////////////////
		ring <= 1'b1;
		cy(3);
		ring <= 1'b0;
		cy(BILL + NOCAR);
		chk("off hook", 1, line.off_hook);
		cy(10);
		chk("off hook", 0, line.off_hook);
		chk("set ready", 1, dte.data_set_ready_n);
		////////////////////////////////////////////////////////////////////////
		bus(1'b1, 8'h00, 32'h2);
		cy(3);
		rd(8'h04, 32'h4, 32'h7);
		chk("to modem", 0, line.line_to_modem);
		car <= 1'b1;
		cy(3);
		chk("off hook", 1, line.off_hook);
		chk("to modem", 1, line.line_to_modem);
		chk("set ready", 0, dte.data_set_ready_n);
		cy(7);
		chk("tx enable", 1, line.tx_enable);
		chk("clear", 1, dte.clear_to_send_n);
		chk("answer tone", 0, line.answer_tone);
		cy(12);
		chk("clear", 0, dte.clear_to_send_n);
		bus(1'b1, 8'h00, 32'ha);
		want_snd <= 1'b1;
		cy(4);
		chk("clear", 1, dte.clear_to_send_n);
		cy(8);
		chk("clear", 0, dte.clear_to_send_n);
		bus(1'b1, 8'h00, 32'h6);
		repeat (4) begin
			r = $urandom;
			txb <= r[0];
			want_snd <= r[1];
			rxd <= r[2];
			cy(4);
			chk("loop rx", r[0], dte.rx_serial_out);
			chk("loop clear", !r[1], dte.clear_to_send_n);
			chk("loop tx", r[2], line.tx_line_data);
		end
		want_rdy <= 1'b0;
		cy(3);
		chk("off hook", 0, line.off_hook);
		chk("set ready", 1, dte.data_set_ready_n);
		car <= 1'b0;
		cy(4);
		wrap_up();
	end
endmodule
